// file: dv/scr_host.sv
// spi host model for the three-wire control port
`timescale 1ns/10ps
module scr_host (
   input wire logic sys_clk,
   input wire logic spi_sdio_o,
   input wire logic spi_sdio_oe_n,
   output logic spi_sclk,
   output logic spi_csb_n,
   output wire logic spi_sdio_i
);
   logic d = 1'b0;
   initial spi_sclk = 1'b0;
   initial spi_csb_n = 1'b1;
   // host bit toggles while released, so a stale level never reads as data
   assign spi_sdio_i = spi_sdio_oe_n ? d : spi_sdio_o;
   task automatic go(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // first byte travels in rq/wd [15:8]
   task automatic xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd,
         input int nb, input logic lsb, output logic [15:0] rq);
      int j;
      int k;
      rq = 16'h0000;
      spi_csb_n = 1'b0;
      for (int i = 0; i < 16 + 8 * nb; i++) begin
         j = (i - 16) / 8;
         k = (i < 16) ? (lsb ? i : 15 - i) : (lsb ? (i - 16) % 8 : 7 - (i - 16) % 8);
         if (i < 16) d = (k == 15) ? rd : a[k];
         else if (!rd) d = wd[8 * (1 - j) + k];
         else d = ~d;
         go(5);
         if (i >= 16 && rd) rq[8 * (1 - j) + k] = spi_sdio_i;
         spi_sclk = 1'b1;
         go(5);
         spi_sclk = 1'b0;
      end
      go(5);
      spi_csb_n = 1'b1;
      go(6);
   endtask
endmodule

// file: dv/scr_regbank_bench.sv
// self-checking bench for the spi register bank
`timescale 1ns/10ps
module scr_regbank_bench;
   import scr_pkg::*;
   localparam int BOOT = 400;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic ord = 1'b0;
   wire sclk, csb_n, sdi, sdo, oe_n;
   scr_regs_t regs;
   scr_regs_t keep;
   scr_status_s st;
   int bad_count = 0;
   int n_compared = 0;
   logic [15:0] q;
   always #4 sys_clk = ~sys_clk;
   scr_regbank #(.BOOT_CYCLES(BOOT)) uut (.sys_clk, .rstn, .spi_sclk(sclk), .spi_csb_n(csb_n),
      .spi_sdio_i(sdi), .spi_sdio_o(sdo), .spi_sdio_oe_n(oe_n), .ctrl_regs(regs), .status(st));
   scr_host host (.sys_clk, .spi_sdio_o(sdo), .spi_sdio_oe_n(oe_n), .spi_sclk(sclk),
      .spi_csb_n(csb_n), .spi_sdio_i(sdi));
   task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] v);
      host.xfer(1'b0, a, {v, 8'h00}, 1, ord, q);
   endtask
   task automatic rd(input logic [14:0] a);
      host.xfer(1'b1, a, 16'h0000, 1, ord, q);
   endtask
   task automatic t_coupling();
      wr(15'h1908, 8'hff);
      check("coupling", 8'h04, regs[11]);
      rd(15'h1908);
      check("coupling rd", 8'h04, q[15:8]);
   endtask
   task automatic t_iface();
      wr(15'h0000, 8'h5e);
      check("status", 3'b110, st);
      ord = 1'b1;
      rd(15'h0000);
      check("cfg rd", 8'h66, q[15:8]);
      host.xfer(1'b0, 15'h18e0, 16'ha53c, 2, ord, q);
      check("burst lsb", 16'h3ca5, {regs[7], regs[6]});
      wr(15'h0000, 8'h00);
      ord = 1'b0;
      check("status", 3'b000, st);
      host.xfer(1'b0, 15'h18e0, 16'h5ac3, 2, ord, q);
      host.xfer(1'b1, 15'h18e0, 16'h0000, 2, ord, q);
      check("burst rd", 16'h5ac3, q);
   endtask
   task automatic t_unmapped();
      // the host never writes an unlisted address; a read must not disturb the bank
      keep = regs;
      rd(15'h0005);
      check("unmapped", {keep, 8'h00}, {regs, q[15:8]});
   endtask
   task automatic t_srst();
      int n;
      wr(15'h0922, 8'h11);
      wr(15'h0000, 8'h80);
      check("srst", {REG_RESET, 1'b1}, {regs, st.boot_busy});
      // only reads are allowed inside the wait
      rd(15'h0922);
      check("boot value", 8'h70, q[15:8]);
      n = 0;
      while (st.boot_busy !== 1'b0 && n < BOOT) begin
         host.go(1);
         n++;
      end
      check("boot end", 1'b0, st.boot_busy);
      wr(15'h0922, 8'h33);
      check("after boot", 8'h33, regs[1]);
   endtask
   initial begin
      #160000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      host.go(3);
      check("reset", {REG_RESET, 3'b000}, {regs, st});
      t_coupling();
      t_iface();
      t_unmapped();
      t_srst();
      complete_run();
   end
endmodule

// file: dv/scr_regbank_sva.sv
// assertions on the register bank ports
`timescale 1ns/10ps
module scr_regbank_sva #(
   parameter int BOOT_CYCLES = scr_pkg::BOOT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic spi_sclk,
   input wire logic spi_csb_n,
   input wire logic spi_sdio_i,
   input wire logic spi_sdio_o,
   input wire logic spi_sdio_oe_n,
   input wire scr_pkg::scr_regs_t ctrl_regs,
   input wire scr_pkg::scr_status_s status
);
   import scr_pkg::*;
   logic [19:0] busy_r;
   logic [19:0] busy_nxt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   always_comb busy_nxt = status.boot_busy ? busy_r + 20'h1 : 20'h0;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) busy_r <= 20'h0;
      else busy_r <= busy_nxt;
   end
   sequence s_boot_start;
      $rose(status.boot_busy);
   endsequence
   a_reset_values: assert property ($rose(rstn) |-> ctrl_regs == REG_RESET && status == '0)
      else $error("bank not at reset values");
   a_srst_restores: assert property (s_boot_start |-> ctrl_regs == REG_RESET)
      else $error("soft reset left registers changed");
   a_srst_order: assert property (status.boot_busy |-> !status.lsb_first && !status.addr_asc)
      else $error("bit order not cleared by soft reset");
   a_boot_bounded: assert property (busy_r <= BOOT_CYCLES)
      else $error("boot restore too long");
   a_boot_frozen: assert property (s_boot_start ##1 status.boot_busy |-> $stable(ctrl_regs))
      else $error("register changed during boot");
   a_coupling_bits: assert property ((ctrl_regs[11] & 8'hfb) == 8'h00)
      else $error("coupling reserved bit set");
   a_reserved_zero: assert property ((ctrl_regs & ~REG_WMASK) == '0)
      else $error("reserved bit set");
   a_oe_framed: assert property (!spi_sdio_oe_n |-> !$past(spi_csb_n, 5))
      else $error("sdio driven outside a frame");
endmodule
bind scr_regbank scr_regbank_sva #(.BOOT_CYCLES(BOOT_CYCLES)) u_sva (.sys_clk, .rstn, .spi_sclk,
   .spi_csb_n, .spi_sdio_i, .spi_sdio_o, .spi_sdio_oe_n, .ctrl_regs, .status);

// file: src/scr_pkg.sv
// constants, register map and carrier types for the spi configuration register bank
package scr_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SRST_WAIT_MS = 5;
   // boot restore must be over by the end of the host's wait; longest time rounds down
   localparam int BOOT_CYCLES = (SRST_WAIT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int BOOT_W = 20;

   localparam int ADDR_W = 15;
   localparam int INSTR_W = 16;
   localparam int NREG = 15;
   localparam int IDX_W = 4;

   localparam logic [14:0] ADDR_IFACE_CFG = 15'h0000;

   // interface config field positions
   localparam int SRST_BIT = 7;
   localparam int LSB_MIR_BIT = 6;
   localparam int ASC_MIR_BIT = 5;
   localparam int ASC_BIT = 2;
   localparam int LSB_BIT = 1;
   localparam int SRST_MIR_BIT = 0;

   typedef logic [7:0] scr_byte_t;
   typedef logic [NREG-1:0][7:0] scr_regs_t;

   // order: 05c6 0922 1222 1228 1262 18a6 18e0 18e1 18e2 18e3 18e6 1908 1910 1a4c 1a4d
   localparam logic [NREG-1:0][14:0] REG_ADDR = {
      15'h1a4d, 15'h1a4c, 15'h1910, 15'h1908, 15'h18e6, 15'h18e3, 15'h18e2, 15'h18e1,
      15'h18e0, 15'h18a6, 15'h1262, 15'h1228, 15'h1222, 15'h0922, 15'h05c6};
   localparam scr_regs_t REG_RESET = {
      8'h0c, 8'h0c, 8'h0d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h70, 8'h00};
   // reserved bits are kept at zero by masking every write
   localparam scr_regs_t REG_WMASK = {
      8'h3f, 8'h3f, 8'h0f, 8'h04, 8'h01, 8'h7f, 8'hff, 8'hff,
      8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

   typedef enum logic [1:0] {
      SCR_IDLE = 2'b00,
      SCR_INSTR = 2'b01,
      SCR_DATA = 2'b10,
      SCR_HOLD = 2'b11
   } scr_state_e;

   typedef struct packed {
      logic lsb_first;
      logic addr_asc;
      logic boot_busy;
   } scr_status_s;
endpackage

// file: src/scr_regbank.sv
// spi slave register bank holding interface configuration and converter controls
`timescale 1ns/10ps
module scr_regbank #(
   parameter int BOOT_CYCLES = scr_pkg::BOOT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic spi_sclk,
   input wire logic spi_csb_n,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe_n,
   output scr_pkg::scr_regs_t ctrl_regs,
   output scr_pkg::scr_status_s status
);
   import scr_pkg::*;

   localparam logic [BOOT_W-1:0] BOOT_LOAD = BOOT_W'(BOOT_CYCLES);

   function automatic logic [IDX_W:0] reg_lookup(input logic [ADDR_W-1:0] a);
      logic [IDX_W:0] res;
      res = '0;
      for (int i = 0; i < NREG; i++) begin
         if (REG_ADDR[i] == a) begin
            res = {1'b1, IDX_W'(i)};
         end
      end
      return res;
   endfunction

   // unmapped addresses read as zero
   function automatic scr_byte_t read_byte(input logic [ADDR_W-1:0] a, input scr_regs_t regs,
                                            input logic lsb, input logic asc);
      logic [IDX_W:0] hit;
      scr_byte_t res;
      hit = reg_lookup(a);
      res = 8'h00;
      if (a == ADDR_IFACE_CFG) begin
         res = {1'b0, lsb, asc, 2'b00, asc, lsb, 1'b0};
      end else if (hit[IDX_W]) begin
         res = regs[hit[IDX_W-1:0]];
      end
      return res;
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] v);
      logic [7:0] res;
      res = '0;
      for (int i = 0; i < 8; i++) begin
         res[i] = v[7-i];
      end
      return res;
   endfunction

   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] res;
      res = '0;
      for (int i = 0; i < 16; i++) begin
         res[i] = v[15-i];
      end
      return res;
   endfunction

   // pins come from the host's domain; two flops before use, third only for edges
   logic [2:0] sclk_sync_r;
   logic [1:0] csb_sync_r;
   logic [1:0] sdi_sync_r;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_sync_r <= 3'b000;
         csb_sync_r <= 2'b11;
         sdi_sync_r <= 2'b00;
      end else begin
         sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
         csb_sync_r <= {csb_sync_r[0], spi_csb_n};
         sdi_sync_r <= {sdi_sync_r[0], spi_sdio_i};
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic csb_hi;
   logic sdi;
   assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
   assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
   assign csb_hi = csb_sync_r[1];
   assign sdi = sdi_sync_r[1];

   scr_state_e st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [15:0] sh_r, sh_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic rd_r, rd_nxt;
   scr_byte_t tx_r, tx_nxt;
   logic sdo_r, sdo_nxt;
   logic oen_r, oen_nxt;
   scr_regs_t regs_r, regs_nxt;
   logic lsb_r, lsb_nxt;
   logic asc_r, asc_nxt;
   logic [BOOT_W-1:0] boot_r, boot_nxt;
   logic busy_r, busy_nxt;

   always_comb begin
      logic [15:0] instr;
      logic [7:0] wd;
      logic [IDX_W:0] hit;
      logic [ADDR_W-1:0] addr_inc;
      instr = '0;
      wd = '0;
      hit = '0;
      addr_inc = addr_r + 15'h0001;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      addr_nxt = addr_r;
      rd_nxt = rd_r;
      tx_nxt = tx_r;
      sdo_nxt = sdo_r;
      oen_nxt = oen_r;
      regs_nxt = regs_r;
      lsb_nxt = lsb_r;
      asc_nxt = asc_r;
      boot_nxt = (boot_r != '0) ? boot_r - BOOT_W'(1) : boot_r;
      busy_nxt = (boot_r > BOOT_W'(1));
      if (csb_hi) begin
         st_nxt = SCR_IDLE;
         oen_nxt = 1'b1;
      end else begin
         case (st_r)
            SCR_IDLE: begin
               st_nxt = SCR_INSTR;
               cnt_nxt = 4'h0;
            end
            SCR_INSTR: begin
               if (sclk_rise) begin
                  sh_nxt = {sh_r[14:0], sdi};
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == 4'hf) begin
                     // instruction order follows the bit order too
                     instr = lsb_r ? rev16({sh_r[14:0], sdi}) : {sh_r[14:0], sdi};
                     rd_nxt = instr[15];
                     addr_nxt = instr[14:0];
                     tx_nxt = read_byte(instr[14:0], regs_r, lsb_r, asc_r);
                     cnt_nxt = 4'h0;
                     st_nxt = SCR_DATA;
                  end
               end
            end
            SCR_DATA: begin
               if (sclk_fall && rd_r) begin
                  sdo_nxt = lsb_r ? tx_r[0] : tx_r[7];
                  tx_nxt = lsb_r ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
                  oen_nxt = 1'b0;
               end
               if (sclk_rise) begin
                  sh_nxt = {sh_r[14:0], sdi};
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == 4'h7) begin
                     cnt_nxt = 4'h0;
                     wd = lsb_r ? rev8({sh_r[6:0], sdi}) : {sh_r[6:0], sdi};
                     // same step whatever the ascension bits hold
                     addr_nxt = addr_inc;
                     tx_nxt = read_byte(addr_inc, regs_r, lsb_r, asc_r);
                     hit = reg_lookup(addr_r);
                     // writes during boot restore are dropped rather than racing the reload
                     if (!rd_r && !busy_r) begin
                        if (addr_r == ADDR_IFACE_CFG) begin
                           if (wd[SRST_BIT] | wd[SRST_MIR_BIT]) begin
                              regs_nxt = REG_RESET;
                              lsb_nxt = 1'b0;
                              asc_nxt = 1'b0;
                              boot_nxt = BOOT_LOAD;
                              busy_nxt = 1'b1;
                              oen_nxt = 1'b1;
                              st_nxt = SCR_HOLD;
                           end else begin
                              lsb_nxt = wd[LSB_MIR_BIT] | wd[LSB_BIT];
                              asc_nxt = wd[ASC_MIR_BIT] | wd[ASC_BIT];
                           end
                        end else if (hit[IDX_W]) begin
                           // reserved bits, including those around the coupling bit, stay zero
                           regs_nxt[hit[IDX_W-1:0]] = wd & REG_WMASK[hit[IDX_W-1:0]];
                        end
                     end
                  end
               end
            end
            SCR_HOLD: begin
               oen_nxt = 1'b1;
            end
            default: begin
               st_nxt = SCR_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= SCR_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 16'h0000;
         addr_r <= 15'h0000;
         rd_r <= 1'b0;
         tx_r <= 8'h00;
         sdo_r <= 1'b0;
         oen_r <= 1'b1;
         regs_r <= REG_RESET;
         lsb_r <= 1'b0;
         asc_r <= 1'b0;
         boot_r <= '0;
         busy_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         addr_r <= addr_nxt;
         rd_r <= rd_nxt;
         tx_r <= tx_nxt;
         sdo_r <= sdo_nxt;
         oen_r <= oen_nxt;
         regs_r <= regs_nxt;
         lsb_r <= lsb_nxt;
         asc_r <= asc_nxt;
         boot_r <= boot_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign spi_sdio_o = sdo_r;
   assign spi_sdio_oe_n = oen_r;
   assign ctrl_regs = regs_r;
   assign status = '{lsb_first: lsb_r, addr_asc: asc_r, boot_busy: busy_r};
endmodule
